/* dv/smp_host_model.sv */
// Host controller model: offers move commands to the generator.
// Assumes the caller waits for idle before each send.
`timescale 1ns/1ps
module smp_host_model (
  input wire logic ref_clk,
  output smp_pkg::smp_cmd_s cmd,
  output logic cmd_valid
);
  // Bus starts idle at time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // Turns steps per second squared into the per-millisecond unit.
  // rate unit conversion
  function automatic logic [smp_pkg::W_ACC-1:0] per_ms(input logic [31:0] a);
    logic [31:0] q;
    q = a / 32'd1000;
    return q[smp_pkg::W_ACC-1:0];
  endfunction : per_ms
  // Holds one command over one edge, then scrambles the idle bus.
  // ranges kept by caller
  task automatic send(input smp_pkg::smp_cmd_s c);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd = c;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd = ~c;
  endtask : send
endmodule : smp_host_model

/* dv/smp_profile_gen_props.sv */
// Port checker of the move profile generator.
// Assumes a bind onto smp_profile_gen; one clock, async low reset.
`timescale 1ns/1ps
module smp_profile_gen_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire smp_pkg::smp_cmd_s cmd,
  input wire logic preset_valid,
  input wire logic signed [31:0] preset_value,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic signed [31:0] motor_pos,
  input wire logic enc_clr,
  input wire smp_pkg::smp_stat_s status
);
  localparam int PLAN_MIN = 500;
  localparam int PLAN_MAX = 1000;
  logic take;
  logic rel_ok;
  logic [9:0] age_reg;
  logic [9:0] age_next;
  logic pre_reg;
  logic pre_next;
  logic signed [31:0] pval_reg;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Accepted moves, and relative ones with a legal nonzero offset.
  assign take = cmd_valid && !status.busy;
  assign rel_ok = take && cmd.kind == smp_pkg::MV_REL && cmd.target != 0
    && cmd.target <= 32'sh007F_FFFF && cmd.target >= -32'sh007F_FFFF;
  // Cycle age since the last take, and a pending preset.
  always_comb begin
    age_next = (age_reg == 10'h3FF) ? age_reg : age_reg + 10'h001;
    if (take) begin
      age_next = 10'h000;
    end
    pre_next = preset_valid && !cmd_valid && !status.busy;
  end
  // Registers the helper state.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      age_reg <= 10'h000;
      pre_reg <= 1'b0;
      pval_reg <= 32'sh0;
    end else begin
      age_reg <= age_next;
      pre_reg <= pre_next;
      pval_reg <= preset_value;
    end
  end
  step_count_a: assert property (step_out |-> motor_pos - $past(motor_pos)
    == (dir_out ? 32'sh0000_0001 : 32'shFFFF_FFFF)) else $error("step moved position wrongly");
  pos_cause_a: assert property ($changed(motor_pos)
    |-> step_out || enc_clr || $past(preset_valid)) else $error("position changed alone");
  preset_load_a: assert property (pre_reg
    |-> motor_pos == pval_reg && status.pos_valid) else $error("preset not loaded");
  home_clear_a: assert property (enc_clr |-> motor_pos == 32'sh0
    && status.done && status.pos_valid) else $error("home did not clear");
  plan_first_a: assert property ((step_out || status.done || $rose(status.error))
    |-> age_reg > PLAN_MIN) else $error("acted before planning ended");
  err_quiet_a: assert property (status.error |-> !step_out) else $error("step on error");
  done_pulse_a: assert property (status.done |=> !status.done) else $error("done too long");
  rel_dir_a: assert property (rel_ok |=> dir_out != $past(cmd.target[31]))
    else $error("relative direction wrong");
  jog_dir_a: assert property (take && cmd.kind == smp_pkg::MV_JOG_CW |=> dir_out)
    else $error("positive jog not clockwise");
  abs_home_a: assert property (take && cmd.kind == smp_pkg::MV_ABS && !status.pos_valid
    |-> ##[PLAN_MIN:PLAN_MAX] status.error) else $error("homeless absolute ran");
  cover property (enc_clr);
  cover property (step_out && !dir_out);
  cover property ($rose(status.error));
  cover property (pre_reg);
endmodule : smp_profile_gen_props

bind smp_profile_gen smp_profile_gen_props chk_u (.ref_clk(ref_clk),
  .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
  .preset_valid(preset_valid), .preset_value(preset_value),
  .step_out(step_out), .dir_out(dir_out), .motor_pos(motor_pos),
  .enc_clr(enc_clr), .status(status));

/* dv/tb_top.sv */
// Self-checking bench of the move profile generator.
// Assumes the checker binds itself; clock is 40 MHz.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid;
  smp_pkg::smp_cmd_s cmd;
  logic [smp_pkg::W_SPD-1:0] start_speed = 21'h0F_4240;
  logic preset_valid = 1'b0;
  logic signed [31:0] preset_value = 32'sh0;
  logic home_in = 1'b0;
  logic step_out;
  logic dir_out;
  logic signed [31:0] motor_pos;
  logic enc_clr;
  smp_pkg::smp_stat_s status;
  int error_cnt = 0;
  int comparisons = 0;
  int steps = 0;
  int clrs = 0;
  int seed = 32'h6C59;
  logic signed [31:0] pos_exp = 32'sh0;
  smp_pkg::smp_cmd_s c;
  logic [12:0] jt [4] = '{13'h0, 13'h1, 13'h2, 13'h1388};

  // Free-running clock.
  always #12.5 ref_clk = ~ref_clk;

  smp_profile_gen dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .start_speed(start_speed),
    .preset_valid(preset_valid), .preset_value(preset_value),
    .home_in(home_in), .step_out(step_out), .dir_out(dir_out),
    .motor_pos(motor_pos), .enc_clr(enc_clr), .status(status));
  smp_host_model host_u (.ref_clk(ref_clk), .cmd(cmd), .cmd_valid(cmd_valid));

  // Counts step pulses and encoder clears.
  always @(posedge ref_clk) begin
    if (step_out === 1'b1) steps++;
    if (enc_clr === 1'b1) clrs++;
  end

  task automatic chk_val(input logic signed [31:0] g, input logic signed [31:0] e,
                         input string w);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: %s is %0d not %0d", $time, w, g, e);
    end
  endtask : chk_val

  task automatic chk_bit(input logic g, input logic e, input string w);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: %s is %b not %b", $time, w, g, e);
    end
  endtask : chk_bit

  // Random legal command of the given kind and target.
  function automatic smp_pkg::smp_cmd_s mk(input smp_pkg::smp_move_e k,
                                           input logic signed [31:0] t);
    smp_pkg::smp_cmd_s r;
    r.kind = k;
    r.target = t;
    r.speed = 21'h0F_4240 + 21'($unsigned($random(seed)) % 32'hD_BBA0);
    r.accel = host_u.per_ms(32'h7D0 + $unsigned($random(seed)) % 32'h7_A120);
    r.decel = host_u.per_ms(32'h7D0 + $unsigned($random(seed)) % 32'h7_A120);
    r.jerk = 13'($unsigned($random(seed)) % 32'h1389);
    return r;
  endfunction : mk

  // Expected position at the end of a move.
  function automatic logic signed [31:0] pos_after(input smp_pkg::smp_cmd_s m,
                                                   input logic signed [31:0] p);
    logic signed [31:0] a;
    a = m.target < 0 ? -m.target : m.target;
    case (m.kind)
      smp_pkg::MV_ABS: return m.target;
      smp_pkg::MV_JOG_CW: return p + a;
      smp_pkg::MV_JOG_CCW: return p - a;
      default: return p + m.target;
    endcase
  endfunction : pos_after

  // Waits for done or error under a bound.
  task automatic wait_end();
    int k;
    k = 0;
    @(negedge ref_clk);
    while (status.done !== 1'b1 && status.error !== 1'b1 && k < 20000) begin
      @(negedge ref_clk);
      k++;
    end
    // One more edge lets the step and clear counters see the last pulse.
    @(negedge ref_clk);
    chk_bit(k < 20000, 1'b1, "finish");
  endtask : wait_end

  // Sends a move, then checks error, step count and position.
  task automatic run(input smp_pkg::smp_cmd_s m, input logic err);
    logic signed [31:0] e;
    logic signed [31:0] d;
    e = err ? pos_exp : pos_after(m, pos_exp);
    d = e - pos_exp;
    steps = 0;
    host_u.send(m);
    chk_bit(status.busy, 1'b1, "busy");
    if (d != 0) chk_bit(dir_out, d > 0, "direction");
    wait_end();
    chk_bit(status.error, err, "error");
    chk_val(steps, d < 0 ? -d : d, "steps");
    chk_val(motor_pos, e, "position");
    pos_exp = e;
  endtask : run

  task automatic preset(input logic signed [31:0] v);
    @(negedge ref_clk);
    preset_value = v;
    preset_valid = 1'b1;
    @(negedge ref_clk);
    preset_valid = 1'b0;
    @(negedge ref_clk);
    chk_val(motor_pos, v, "preset");
    pos_exp = v;
  endtask : preset

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (99000) @(posedge ref_clk);
    error_cnt++;
    results();
  end

  // Main sequence.
  initial begin
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    chk_val(motor_pos, 32'sh0, "reset position");
    run(mk(smp_pkg::MV_ABS, 32'sh5), 1'b1);
    for (int i = 0; i < 6; i++) begin
      run(mk(smp_pkg::MV_REL, ($random(seed) % 40) | 1), 1'b0);
    end
    c = mk(smp_pkg::MV_REL, 32'sh5);
    c.speed = 21'h0;
    run(c, 1'b1);
    c = mk(smp_pkg::MV_REL, 32'sh5);
    c.jerk = 13'h1389;
    run(c, 1'b1);
    c.jerk = 13'h0;
    c.accel = 20'h0;
    run(c, 1'b1);
    run(mk(smp_pkg::MV_REL, 32'sh0080_0000), 1'b1);
    run(mk(smp_pkg::MV_REL, -32'sh0080_0000), 1'b1);
    start_speed = 21'h0;
    run(mk(smp_pkg::MV_REL, 32'sh4), 1'b1);
    start_speed = 21'h1E_8480;
    run(mk(smp_pkg::MV_REL, 32'sh4), 1'b1);
    start_speed = 21'h1E_847F;
    run(mk(smp_pkg::MV_REL, -32'sh3), 1'b0);
    start_speed = 21'h0F_4240;
    for (int i = 0; i < 4; i++) begin
      c = mk(smp_pkg::MV_REL, 32'sh4);
      c.jerk = jt[i];
      run(c, 1'b0);
    end
    host_u.send(mk(smp_pkg::MV_HOME_CW, 32'sh0));
    repeat (800) @(negedge ref_clk);
    home_in = 1'b1;
    wait_end();
    home_in = 1'b0;
    chk_val(motor_pos, 32'sh0, "home position");
    chk_val(clrs, 1, "encoder clears");
    chk_bit(status.pos_valid, 1'b1, "home valid");
    pos_exp = 32'sh0;
    run(mk(smp_pkg::MV_ABS, 32'sh19), 1'b0);
    run(mk(smp_pkg::MV_ABS, -32'sh7), 1'b0);
    run(mk(smp_pkg::MV_ABS, -32'sh7), 1'b0);
    run(mk(smp_pkg::MV_JOG_CW, 32'sh5), 1'b0);
    run(mk(smp_pkg::MV_JOG_CCW, 32'sh6), 1'b0);
    preset(32'sh7FFF_FFF0);
    run(mk(smp_pkg::MV_REL, 32'sh28), 1'b0);
    results();
  end
endmodule : tb_top

/* hw/smp_div.sv */
// Sequential restoring divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse and operands hold while it runs.
`timescale 1ns/1ps
module smp_div (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [smp_pkg::W_DIV-1:0] num,
  input wire logic [smp_pkg::W_DIV-1:0] den,
  output logic done,
  output logic [smp_pkg::W_DIV-1:0] quo
);
  logic [smp_pkg::W_DIV:0] rem_reg, rem_next, rem_sh;
  logic [smp_pkg::W_DIV-1:0] quo_next;
  logic [6:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_next;

  // Shifts one numerator bit into the remainder and subtracts if it fits.
  // A zero divisor yields all ones, a result the caller never uses for motion.
  always_comb begin
    rem_next = rem_reg;
    quo_next = quo;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    rem_sh = {rem_reg[smp_pkg::W_DIV-1:0], quo[smp_pkg::W_DIV-1]};
    if (start) begin
      rem_next = '0;
      quo_next = num;
      cnt_next = '0;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (rem_sh >= {1'b0, den}) begin
        rem_next = rem_sh - {1'b0, den};
        quo_next = {quo[smp_pkg::W_DIV-2:0], 1'b1};
      end else begin
        rem_next = rem_sh;
        quo_next = {quo[smp_pkg::W_DIV-2:0], 1'b0};
      end
      cnt_next = cnt_reg + 7'h01;
      if (cnt_reg == 7'(smp_pkg::W_DIV - 1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  // Registers the divider state.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rem_reg <= '0;
      quo <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      rem_reg <= rem_next;
      quo <= quo_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done <= done_next;
    end
  end
endmodule : smp_div

/* hw/smp_pkg.sv */
// Constants and carrier types of the stepper move profile generator.
// Assumes one 40 MHz clock; host move parameters arrive as one struct.
package smp_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned SPD_MIN = 1;
  localparam int unsigned SPD_MAX = 1_999_999;
  localparam int TGT_LIM = 8_388_607;
  localparam int unsigned JERK_MAX = 5000;
  localparam int W_SPD = 21;
  localparam int W_ACC = 20;
  localparam int W_JRK = 13;
  localparam int W_CNT = 33;
  localparam int W_ACU = 26;
  localparam int W_TCK = 16;
  localparam int W_DIV = 64;
  localparam int W_OP = 4;
  localparam int N_OPS = 9;
  localparam logic signed [31:0] POS_RST = 32'sh0000_0000;

  typedef enum logic [2:0] {
    MV_REL, MV_ABS, MV_JOG_CW, MV_JOG_CCW, MV_HOME_CW, MV_HOME_CCW
  } smp_move_e;
  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_RUN} smp_state_e;
  typedef enum logic [1:0] {PH_ACC, PH_CRU, PH_DEC} smp_phase_e;

  typedef struct packed {
    smp_move_e kind;
    logic signed [31:0] target;
    logic [W_SPD-1:0] speed;
    logic [W_ACC-1:0] accel;
    logic [W_ACC-1:0] decel;
    logic [W_JRK-1:0] jerk;
  } smp_cmd_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic error;
    logic pos_valid;
  } smp_stat_s;

  typedef struct packed {
    smp_state_e st;
    smp_phase_e ph;
    logic home;
    logic dir;
    logic err;
    logic [W_CNT-1:0] n;
    logic [W_CNT-1:0] cnt;
    logic [W_CNT-1:0] dec_at;
    logic signed [31:0] pos;
    logic [W_SPD-1:0] v;
    logic [W_SPD-1:0] vp;
    logic [W_SPD-1:0] vs;
    logic [W_ACC-1:0] a;
    logic [W_ACC-1:0] d;
    logic [W_JRK-1:0] jerk;
    logic [W_ACC-1:0] rate;
    logic [31:0] t;
    logic [W_TCK-1:0] tick;
    logic [W_ACU-1:0] acu;
    logic [W_OP-1:0] op;
    logic div_go;
    logic step;
    logic enc_clr;
    smp_stat_s stat;
  } smp_ctx_s;
endpackage : smp_pkg

/* hw/smp_profile_gen.sv */
// Move profile generator: plans a ramp profile, then issues step pulses.
// Assumes the host holds cmd while cmd_valid is high and busy is low.
`timescale 1ns/1ps
module smp_profile_gen (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire smp_pkg::smp_cmd_s cmd,
  input wire logic [smp_pkg::W_SPD-1:0] start_speed,
  input wire logic preset_valid,
  input wire logic signed [31:0] preset_value,
  input wire logic home_in,
  output logic step_out,
  output logic dir_out,
  output logic signed [31:0] motor_pos,
  output logic enc_clr,
  output smp_pkg::smp_stat_s status
);
  localparam logic [63:0] DIST_DEN = 64'(2 * smp_pkg::MS_PER_S);
  localparam logic [63:0] JERK_DEN = 64'(smp_pkg::JERK_MAX);

  smp_pkg::smp_ctx_s c_reg, c_next;
  logic [63:0] res_reg [smp_pkg::N_OPS];
  logic [63:0] res_next [smp_pkg::N_OPS];
  logic home_s1_reg, home_s2_reg;
  logic div_done;
  logic [63:0] div_num, div_den, div_quo;
  logic [63:0] dv, jw, da31, dd31, sum_sp;
  logic signed [32:0] delta;
  logic [smp_pkg::W_SPD:0] v_up;
  logic [smp_pkg::W_ACU-1:0] acu_sum;
  logic tk, stp, bad;

  // Ramp rate for one millisecond tick: rises by inc over the curved
  // start, holds at rmax in the linear middle, falls over the curved end.
  function automatic logic [smp_pkg::W_ACC-1:0] smp_rate(
    input logic [smp_pkg::W_ACC-1:0] r,
    input logic [smp_pkg::W_ACC-1:0] rmax,
    input logic [31:0] t,
    input logic [31:0] rise,
    input logic [31:0] total,
    input logic [smp_pkg::W_ACC-1:0] inc
  );
    logic [smp_pkg::W_ACC:0] up;
    up = {1'b0, r} + {1'b0, inc};
    if (rise == 32'h0000_0000) begin
      smp_rate = rmax;
    end else if (t < rise) begin
      smp_rate = (up > {1'b0, rmax}) ? rmax : up[smp_pkg::W_ACC-1:0];
    end else if (t + rise >= total) begin
      smp_rate = (r > inc) ? r - inc : inc;
    end else begin
      smp_rate = rmax;
    end
  endfunction : smp_rate

  // Home switch comes from a pin and is synchronised before use.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      home_s1_reg <= 1'b0;
      home_s2_reg <= 1'b0;
    end else begin
      home_s1_reg <= home_in;
      home_s2_reg <= home_s1_reg;
    end
  end

  // Planning operands: each op is one division whose result lands in
  // res_reg[op]: 0/1 linear ramp ticks, 2/3 curved-end ticks,
  // 4/5 ramp steps, 6 triangular accel steps, 7/8 jerk increments.
  always_comb begin
    dv = 64'(c_reg.vp - c_reg.vs);
    jw = (c_reg.jerk == '0) ? 64'h0 :
         64'(smp_pkg::JERK_MAX + 1 - 32'(c_reg.jerk));
    da31 = (res_reg[4] > 64'h7FFF_FFFF) ? 64'h7FFF_FFFF : res_reg[4];
    dd31 = (res_reg[5] > 64'h7FFF_FFFF) ? 64'h7FFF_FFFF : res_reg[5];
    sum_sp = 64'(c_reg.vs) + 64'(c_reg.vp);
    case (c_reg.op)
      4'h0: begin
        div_num = dv + 64'(c_reg.a) - 64'h1;
        div_den = 64'(c_reg.a);
      end
      4'h1: begin
        div_num = dv + 64'(c_reg.d) - 64'h1;
        div_den = 64'(c_reg.d);
      end
      4'h2: begin
        div_num = 64'(res_reg[0] * jw);
        div_den = JERK_DEN;
      end
      4'h3: begin
        div_num = 64'(res_reg[1] * jw);
        div_den = JERK_DEN;
      end
      // Ramp distance: mean of start and end speed times ramp time.
      4'h4: begin
        div_num = 64'(sum_sp * (res_reg[0] + res_reg[2]));
        div_den = DIST_DEN;
      end
      4'h5: begin
        div_num = 64'(sum_sp * (res_reg[1] + res_reg[3]));
        div_den = DIST_DEN;
      end
      // short move splits its length in ramp proportion.
      4'h6: begin
        div_num = 64'(64'(c_reg.n) * da31);
        div_den = da31 + dd31;
      end
      4'h7: begin
        div_num = 64'(c_reg.a) + res_reg[2] - 64'h1;
        div_den = res_reg[2];
      end
      4'h8: begin
        div_num = 64'(c_reg.d) + res_reg[3] - 64'h1;
        div_den = res_reg[3];
      end
      default: begin
        div_num = 64'h0;
        div_den = 64'h1;
      end
    endcase
  end

  smp_div u_div (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(c_reg.div_go),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );

  // Move sequencing, step timing, position and status.
  always_comb begin
    c_next = c_reg;
    res_next = res_reg;
    c_next.div_go = 1'b0;
    c_next.step = 1'b0;
    c_next.enc_clr = 1'b0;
    c_next.stat.done = 1'b0;
    tk = 1'b0;
    stp = 1'b0;
    v_up = '0;
    acu_sum = c_reg.acu + smp_pkg::W_ACU'(c_reg.v);
    delta = 33'(cmd.target) - 33'(c_reg.pos);
    bad = (start_speed < smp_pkg::W_SPD'(smp_pkg::SPD_MIN)) ||
          (start_speed > smp_pkg::W_SPD'(smp_pkg::SPD_MAX)) ||
          (cmd.speed == '0) ||
          (cmd.speed > smp_pkg::W_SPD'(smp_pkg::SPD_MAX)) ||
          (cmd.jerk > smp_pkg::W_JRK'(smp_pkg::JERK_MAX)) ||
          (cmd.accel == '0) || (cmd.decel == '0) ||
          (cmd.target > smp_pkg::TGT_LIM) ||
          (cmd.target < -smp_pkg::TGT_LIM);
    case (c_reg.st)
      smp_pkg::ST_IDLE: begin
        if (cmd_valid) begin
          c_next.st = smp_pkg::ST_CALC;
          c_next.op = '0;
          c_next.div_go = 1'b1;
          c_next.stat.error = 1'b0;
          c_next.vs = start_speed;
          c_next.vp = (cmd.speed < start_speed) ? start_speed : cmd.speed;
          c_next.a = cmd.accel;
          c_next.d = cmd.decel;
          // every move type takes the jerk setting.
          c_next.jerk = cmd.jerk;
          c_next.home = 1'b0;
          // absolute moves need an established home.
          c_next.err = bad || (cmd.kind == smp_pkg::MV_ABS &&
                               !c_reg.stat.pos_valid);
          case (cmd.kind)
            // direction from target against current position.
            smp_pkg::MV_ABS: begin
              c_next.dir = !delta[32] && delta != '0;
              c_next.n = delta[32] ? 33'(-delta) : 33'(delta);
            end
            smp_pkg::MV_JOG_CW, smp_pkg::MV_JOG_CCW: begin
              c_next.dir = (cmd.kind == smp_pkg::MV_JOG_CW);
              c_next.n = cmd.target[31] ? 33'(-cmd.target) :
                         33'(cmd.target);
            end
            smp_pkg::MV_HOME_CW, smp_pkg::MV_HOME_CCW: begin
              c_next.dir = (cmd.kind == smp_pkg::MV_HOME_CW);
              c_next.n = '1;
              c_next.home = 1'b1;
            end
            default: begin
              c_next.dir = !cmd.target[31];
              c_next.n = cmd.target[31] ? 33'(-cmd.target) :
                         33'(cmd.target);
            end
          endcase
        end else if (preset_valid) begin
          // preset loads position and establishes home.
          c_next.pos = preset_value;
          c_next.stat.pos_valid = 1'b1;
        end
      end
      smp_pkg::ST_CALC: begin
        if (div_done) begin
          res_next[c_reg.op] = div_quo;
          if (c_reg.op != 4'(smp_pkg::N_OPS - 1)) begin
            c_next.op = c_reg.op + 4'h1;
            c_next.div_go = 1'b1;
          // error and motion wait for the full plan.
          end else if (c_reg.err) begin
            c_next.st = smp_pkg::ST_IDLE;
            c_next.stat.error = 1'b1;
          end else if (c_reg.n == '0) begin
            c_next.st = smp_pkg::ST_IDLE;
            c_next.stat.done = 1'b1;
          end else begin
            c_next.st = smp_pkg::ST_RUN;
            c_next.ph = smp_pkg::PH_ACC;
            // jump straight to the starting speed.
            c_next.v = c_reg.vs;
            c_next.rate = (res_reg[2] == 64'h0) ? c_reg.a : '0;
            c_next.t = '0;
            c_next.tick = '0;
            c_next.acu = '0;
            c_next.cnt = '0;
            if (c_reg.home) begin
              c_next.dec_at = '1;
            end else if (da31 + dd31 < 64'(c_reg.n)) begin
              c_next.dec_at = c_reg.n - 33'(res_reg[5]);
            end else begin
              c_next.dec_at = 33'(res_reg[6]);
            end
          end
        end
      end
      smp_pkg::ST_RUN: begin
        if (c_reg.tick == 16'(smp_pkg::TICK_CYC - 1)) begin
          c_next.tick = '0;
          tk = 1'b1;
        end else begin
          c_next.tick = c_reg.tick + 16'h0001;
        end
        // Phase accumulator: one step each time speed sums past CLK_HZ.
        if (acu_sum >= smp_pkg::W_ACU'(smp_pkg::CLK_HZ)) begin
          stp = 1'b1;
          c_next.acu = acu_sum - smp_pkg::W_ACU'(smp_pkg::CLK_HZ);
          c_next.step = 1'b1;
          c_next.cnt = c_reg.cnt + 33'h1;
          // wrapping count, up clockwise, down otherwise.
          c_next.pos = c_reg.dir ? c_reg.pos + 32'sh1 : c_reg.pos - 32'sh1;
        end else begin
          c_next.acu = acu_sum;
        end
        case (c_reg.ph)
          smp_pkg::PH_ACC, smp_pkg::PH_CRU: begin
            // leave acceleration or cruise at the planned deceleration point.
            if (c_reg.cnt >= c_reg.dec_at) begin
              c_next.ph = smp_pkg::PH_DEC;
              c_next.t = '0;
              c_next.rate = (res_reg[3] == 64'h0) ? c_reg.d : '0;
            end else if (tk && c_reg.ph == smp_pkg::PH_ACC) begin
              c_next.t = c_reg.t + 32'h1;
              c_next.rate = smp_rate(c_reg.rate, c_reg.a, c_reg.t,
                32'(res_reg[2]), 32'(res_reg[0] + res_reg[2]),
                smp_pkg::W_ACC'(res_reg[7]));
              v_up = {1'b0, c_reg.v} + 22'(c_next.rate);
              if (v_up >= {1'b0, c_reg.vp}) begin
                c_next.v = c_reg.vp;
                c_next.ph = smp_pkg::PH_CRU;
              end else begin
                c_next.v = v_up[smp_pkg::W_SPD-1:0];
              end
            end
          end
          default: begin
            // deceleration at its own rate down to start speed.
            if (tk) begin
              c_next.t = c_reg.t + 32'h1;
              c_next.rate = smp_rate(c_reg.rate, c_reg.d, c_reg.t,
                32'(res_reg[3]), 32'(res_reg[1] + res_reg[3]),
                smp_pkg::W_ACC'(res_reg[8]));
              c_next.v = ({1'b0, c_reg.v} >
                          {1'b0, c_reg.vs} + 22'(c_next.rate)) ?
                         c_reg.v - 21'(c_next.rate) : c_reg.vs;
            end
          end
        endcase
        if (c_reg.home && home_s2_reg) begin
          c_next.pos = smp_pkg::POS_RST;
          c_next.enc_clr = 1'b1;
          c_next.stat.pos_valid = 1'b1;
          c_next.step = 1'b0;
          c_next.v = '0;
          c_next.st = smp_pkg::ST_IDLE;
          c_next.stat.done = 1'b1;
        end else if (stp && c_reg.cnt + 33'h1 == c_reg.n) begin
          // final step issued, speed back to zero.
          c_next.v = '0;
          c_next.st = smp_pkg::ST_IDLE;
          c_next.stat.done = 1'b1;
        end
      end
      default: c_next.st = smp_pkg::ST_IDLE;
    endcase
    c_next.stat.busy = (c_next.st != smp_pkg::ST_IDLE);
  end

  // Registers the move context and the planning results.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      c_reg <= '0;
      for (int i = 0; i < smp_pkg::N_OPS; i++) begin
        res_reg[i] <= '0;
      end
    end else begin
      c_reg <= c_next;
      res_reg <= res_next;
    end
  end

  assign step_out = c_reg.step;
  assign dir_out = c_reg.dir;
  assign motor_pos = c_reg.pos;
  assign enc_clr = c_reg.enc_clr;
  assign status = c_reg.stat;
endmodule : smp_profile_gen
